// file: include/abc_defs.vh
/*
  Constants of the address break comparator: register indices, field
  positions, reset values, mode codes and bus answer codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ABC_DEFS_VH
`define ABC_DEFS_VH

// register indices, byte address is four times the index
`define ABC_IDX_CTRL 18'h0f096
`define ABC_IDX_STAT 18'h0f097
`define ABC_IDX_ADDR 18'h0f098
`define ABC_IDX_DATA 18'h0f09a
`define ABC_IDX_IRQ_STAT 18'h0f0a0
`define ABC_IDX_IRQ_MASK 18'h0f0a1

// control field positions
`define ABC_CTRL_RTE 7
`define ABC_CSEL_HI 6
`define ABC_CSEL_LO 5
`define ABC_ACMP_HI 4
`define ABC_ACMP_LO 2
`define ABC_DCMP_HI 1
`define ABC_DCMP_LO 0

// status field positions
`define ABC_STAT_FLAG 7
`define ABC_STAT_EN 6

// interrupt status and mask bit
`define ABC_IRQ_BREAK 0

// reset values
`define ABC_CTRL_RST 8'h00
`define ABC_ADDR_RST 16'h0000
`define ABC_DATA_RST 16'h0000
`define ABC_MASK_RST 1'b0

// condition select codes
`define ABC_CSEL_EXEC 2'b00
`define ABC_CSEL_READ 2'b01
`define ABC_CSEL_WRITE 2'b10
`define ABC_CSEL_ANY 2'b11

// address compare codes
`define ABC_ACMP_FULL 3'b000
`define ABC_ACMP_NO0 3'b001
`define ABC_ACMP_NO4 3'b010
`define ABC_ACMP_NO8 3'b011

// data compare codes
`define ABC_DCMP_NONE 2'b00
`define ABC_DCMP_LOW 2'b01
`define ABC_DCMP_HIGH 2'b10
`define ABC_DCMP_WORD 2'b11

// bus answers
`define ABC_RESP_OKAY 2'b00
`define ABC_RESP_SLVERR 2'b10

`endif

// file: verilog/abc_matcher.v
/*
  Address and data comparator of the break unit.
  Assumes the bus values and settings come from the same clock domain;
  purely combinational, the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
`include "abc_defs.vh"

module abc_matcher (
  // watched bus
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_data,
  input wire cpu_byte,
  // settings
  input wire [15:0] cmp_addr,
  input wire [15:0] cmp_data,
  input wire [2:0] addr_mode,
  input wire [1:0] data_mode,
  // results
  output wire addr_hit,
  output wire data_hit
);

  reg [4:0] ignore_low;
  wire [15:0] addr_care;
  wire upper_eq;
  wire lower_eq;
  reg next_data_hit;

  // number of low address bits left out of the compare
  always @* begin
    case (addr_mode)
      `ABC_ACMP_FULL: ignore_low = 5'd0;
      `ABC_ACMP_NO0: ignore_low = 5'd1;
      `ABC_ACMP_NO4: ignore_low = 5'd4;
      `ABC_ACMP_NO8: ignore_low = 5'd8;
      default: ignore_low = 5'd0;
    endcase
  end

  // per bit care mask, full compare when nothing ignored
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_care
      assign addr_care[i] = (i >= ignore_low);
    end
  endgenerate

  // upper register byte against upper bus half, lower against lower
  assign addr_hit = ((cpu_addr ^ cmp_addr) & addr_care) == 16'h0000;
  assign upper_eq = cpu_data[15:8] == cmp_data[15:8];
  assign lower_eq = cpu_data[7:0] == cmp_data[7:0];

  // data compare by mode; byte data rides the upper lines
  always @* begin
    case (data_mode)
      `ABC_DCMP_NONE: next_data_hit = 1'b1;
      `ABC_DCMP_LOW: next_data_hit = cpu_byte ? upper_eq : lower_eq;
      `ABC_DCMP_HIGH: next_data_hit = upper_eq;
      `ABC_DCMP_WORD: next_data_hit = cpu_byte ? upper_eq : (upper_eq & lower_eq);
      default: next_data_hit = 1'b1;
    endcase
  end
  assign data_hit = next_data_hit;

endmodule
`default_nettype wire

// file: verilog/abc_break_unit.v
/*
  Address break comparator with an AXI4-Lite register slave.
  Watches the core's address and data buses and raises a break
  interrupt request. Assumes the core bus signals and the register bus
  run on ref_clk; no synchronisers are needed for them.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
// Summary of operation
// - in execution mode the event fires only after the matching instruction finishes.
// - a 16-bit compare address is matched against the internal address bus.
// - upper address byte gives upper compare half, lower byte the lower half.
// - upper data byte compares bus bits 15..8, lower byte bits 7..0.
// - byte data travels on the upper eight lines; software uses the upper byte.
// - status holds the break flag and its interrupt enable.
// - control bit 7 set leaves an interrupt right after return unmasked.
// - condition field 00 at bits 6..5 picks instruction execution, no data compare.
// - address field at bits 4..2; 000 means full 16-bit compare.
// - data field at bits 1..0; 00 disables data compare.
// - flag bit 7 sets on the condition, clears by writing 0 after reading 1.
// - status bit 6 set permits break interrupt requests.
`timescale 1ns/1ns
`default_nettype none
`include "abc_defs.vh"

module abc_break_unit #(
  parameter AXI_ADDR_W = 20
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // axi4-lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // axi4-lite write response
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // axi4-lite read data
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  // watched core bus
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_data,
  input wire cpu_insn_start,
  input wire cpu_insn_done,
  input wire cpu_access,
  input wire cpu_write,
  input wire cpu_byte,
  input wire cpu_rte_done,
  // interrupt outputs
  output wire break_irq,
  output wire return_interrupt_unmask,
  output wire irq
);

  // register state
  reg [7:0] break_condition_control;
  reg break_event_flag;
  reg break_event_enable;
  reg [15:0] break_compare_address;
  reg [15:0] break_compare_data;
  reg irq_status;
  reg irq_mask;
  reg flag_seen_set;

  // write channel holding state
  reg aw_held;
  reg w_held;
  reg [AXI_ADDR_W-1:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;

  // break detection state
  reg exec_armed;
  reg after_rte;

  // decoded fields and helpers
  wire [1:0] cond_sel;
  wire [2:0] addr_mode;
  wire [1:0] data_mode;
  wire addr_hit;
  wire data_hit;
  wire do_write;
  wire ar_take;
  wire [17:0] wr_idx;
  wire [17:0] rd_idx;
  wire access_kind_ok;
  wire break_event;
  wire exec_event;
  wire data_event;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_addr_reg;
  wire wr_data_reg;
  wire wr_irq_stat;
  wire wr_irq_mask;
  wire wr_hit;
  wire flag_clear;
  reg [31:0] next_rdata;
  reg next_rd_hit;

  // control fields
  assign cond_sel = break_condition_control[`ABC_CSEL_HI:`ABC_CSEL_LO];
  assign addr_mode = break_condition_control[`ABC_ACMP_HI:`ABC_ACMP_LO];
  assign data_mode = break_condition_control[`ABC_DCMP_HI:`ABC_DCMP_LO];
  assign return_interrupt_unmask = break_condition_control[`ABC_CTRL_RTE];

  // address and data comparator
  abc_matcher u_matcher (
    .cpu_addr(cpu_addr),
    .cpu_data(cpu_data),
    .cpu_byte(cpu_byte),
    .cmp_addr(break_compare_address),
    .cmp_data(break_compare_data),
    .addr_mode(addr_mode),
    .data_mode(data_mode),
    .addr_hit(addr_hit),
    .data_hit(data_hit)
  );

  // execution break: arm on fetch of the first byte, fire on completion
  assign exec_event = (cond_sel == `ABC_CSEL_EXEC) & cpu_insn_done & exec_armed;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      exec_armed <= 1'b0;
    end else if (cond_sel != `ABC_CSEL_EXEC) begin
      exec_armed <= 1'b0;
    end else if (cpu_insn_start) begin
      exec_armed <= addr_hit;
    end else if (cpu_insn_done) begin
      exec_armed <= 1'b0;
    end
  end

  // data access break: read, write or either, plus optional data compare
  assign access_kind_ok = (cond_sel == `ABC_CSEL_ANY) |
                          ((cond_sel == `ABC_CSEL_READ) & ~cpu_write) |
                          ((cond_sel == `ABC_CSEL_WRITE) & cpu_write);
  assign data_event = (cond_sel != `ABC_CSEL_EXEC) & cpu_access & access_kind_ok &
                      addr_hit & data_hit;
  assign break_event = exec_event | data_event;

  // one cycle window right after a return from exception
  always @(posedge ref_clk) begin
    if (!rstn) begin
      after_rte <= 1'b0;
    end else begin
      after_rte <= cpu_rte_done;
    end
  end

  // request while flag and enable are set, held off right after return unless control bit 7 is set
  assign break_irq = break_event_flag & break_event_enable &
                     ~(after_rte & ~return_interrupt_unmask);

  // summary interrupt from sticky status and mask
  assign irq = irq_status & irq_mask;

  // write channel handshakes, address and data in either order
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  always @(posedge ref_clk) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= {AXI_ADDR_W{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode
  assign wr_idx = wr_addr[19:2];
  assign wr_ctrl = wr_idx == `ABC_IDX_CTRL;
  assign wr_stat = wr_idx == `ABC_IDX_STAT;
  assign wr_addr_reg = wr_idx == `ABC_IDX_ADDR;
  assign wr_data_reg = wr_idx == `ABC_IDX_DATA;
  assign wr_irq_stat = wr_idx == `ABC_IDX_IRQ_STAT;
  assign wr_irq_mask = wr_idx == `ABC_IDX_IRQ_MASK;
  assign wr_hit = wr_ctrl | wr_stat | wr_addr_reg | wr_data_reg | wr_irq_stat | wr_irq_mask;

  // write response, error on unmapped address
  always @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ABC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `ABC_RESP_OKAY : `ABC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control, compare address and compare data registers
  always @(posedge ref_clk) begin
    if (!rstn) begin
      break_condition_control <= `ABC_CTRL_RST;
      break_compare_address <= `ABC_ADDR_RST;
      break_compare_data <= `ABC_DATA_RST;
      irq_mask <= `ABC_MASK_RST;
    end else if (do_write) begin
      if (wr_ctrl && wr_strb[0]) begin
        break_condition_control <= wr_data[7:0];
      end
      if (wr_addr_reg && wr_strb[0]) begin
        break_compare_address[7:0] <= wr_data[7:0];
      end
      if (wr_addr_reg && wr_strb[1]) begin
        break_compare_address[15:8] <= wr_data[15:8];
      end
      if (wr_data_reg && wr_strb[0]) begin
        break_compare_data[7:0] <= wr_data[7:0];
      end
      if (wr_data_reg && wr_strb[1]) begin
        break_compare_data[15:8] <= wr_data[15:8];
      end
      if (wr_irq_mask && wr_strb[0]) begin
        irq_mask <= wr_data[`ABC_IRQ_BREAK];
      end
    end
  end

  // a zero written to the flag clears it only after it was read as one
  assign flag_clear = do_write & wr_stat & wr_strb[0] & ~wr_data[`ABC_STAT_FLAG] & flag_seen_set;

  // status flag and enable; a new event beats a clear
  always @(posedge ref_clk) begin
    if (!rstn) begin
      break_event_flag <= 1'b0;
      break_event_enable <= 1'b0;
      flag_seen_set <= 1'b0;
    end else begin
      if (break_event) begin
        break_event_flag <= 1'b1;
      end else if (flag_clear) begin
        break_event_flag <= 1'b0;
      end
      if (do_write && wr_stat && wr_strb[0]) begin
        break_event_enable <= wr_data[`ABC_STAT_EN];
      end
      if (flag_clear || !break_event_flag) begin
        flag_seen_set <= 1'b0;
      end else if (ar_take && rd_idx == `ABC_IDX_STAT) begin
        flag_seen_set <= 1'b1;
      end
    end
  end

  // sticky event status, write one to clear, set wins
  always @(posedge ref_clk) begin
    if (!rstn) begin
      irq_status <= 1'b0;
    end else if (break_event) begin
      irq_status <= 1'b1;
    end else if (do_write && wr_irq_stat && wr_strb[0] && wr_data[`ABC_IRQ_BREAK]) begin
      irq_status <= 1'b0;
    end
  end

  // read channel, one read under way at a time
  assign s_axi_arready = ~s_axi_rvalid;
  assign ar_take = s_axi_arvalid & ~s_axi_rvalid;
  assign rd_idx = s_axi_araddr[19:2];

  // read mux, unused bits read as zero
  always @* begin
    next_rdata = 32'h00000000;
    next_rd_hit = 1'b1;
    case (rd_idx)
      `ABC_IDX_CTRL: next_rdata[7:0] = break_condition_control;
      `ABC_IDX_STAT: begin
        next_rdata[`ABC_STAT_FLAG] = break_event_flag;
        next_rdata[`ABC_STAT_EN] = break_event_enable;
      end
      `ABC_IDX_ADDR: next_rdata[15:0] = break_compare_address;
      `ABC_IDX_DATA: next_rdata[15:0] = break_compare_data;
      `ABC_IDX_IRQ_STAT: next_rdata[`ABC_IRQ_BREAK] = irq_status;
      `ABC_IDX_IRQ_MASK: next_rdata[`ABC_IRQ_BREAK] = irq_mask;
      default: next_rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always @(posedge ref_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ABC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rd_hit ? `ABC_RESP_OKAY : `ABC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: tb/abc_break_props.sv
/*
  Port checker of the break unit, bound at the foot.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module abc_break_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // core strobes
  input wire logic cpu_insn_done,
  input wire logic cpu_access,
  input wire logic cpu_rte_done,
  // interrupt outputs
  input wire logic break_irq,
  input wire logic return_interrupt_unmask,
  input wire logic irq
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // bus answers stand until taken
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_refuse_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // break request timing
  rte_mask_a: assert property (cpu_rte_done && !return_interrupt_unmask |=> !break_irq)
    else $error("request not held off after return");
  unmask_source_a: assert property ($changed(return_interrupt_unmask) |-> $past(s_axi_wvalid, 2))
    else $error("unmask bit moved without a write");
  break_rise_a: assert property ($rose(break_irq) |-> $past(cpu_insn_done) || $past(cpu_access)
    || $past(cpu_rte_done, 2) || $past(s_axi_wvalid, 2))
    else $error("request rose without cause");
  break_fall_a: assert property ($fell(break_irq) |-> $past(cpu_rte_done) || $past(s_axi_wvalid, 2))
    else $error("request fell without cause");
  sys_irq_a: assert property ($rose(irq) |-> $past(cpu_insn_done) || $past(cpu_access) || $past(s_axi_wvalid, 2))
    else $error("interrupt rose without cause");
endmodule

bind abc_break_unit abc_break_props i_abc_break_props (
  .ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_insn_done, .cpu_access,
  .cpu_rte_done, .break_irq, .return_interrupt_unmask, .irq
);

`default_nettype wire

// file: tb/abc_core_model.sv
/*
  Core bus model: drives the watched buses and strobes.
  Assumes the unit samples everything on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module abc_core_model (
  // clock
  input wire logic ref_clk,
  // watched core bus
  output logic [15:0] cpu_addr,
  output logic [15:0] cpu_data,
  output logic cpu_insn_start,
  output logic cpu_insn_done,
  output logic cpu_access,
  output logic cpu_write,
  output logic cpu_byte,
  output logic cpu_rte_done
);
  logic busy;

  // quiet bus at time zero
  initial begin
    busy = 1'b0;
    cpu_addr = 16'h0000;
    cpu_data = 16'h0000;
    {cpu_insn_start, cpu_insn_done, cpu_access, cpu_write, cpu_byte, cpu_rte_done} = 6'h00;
  end

  // idle buses change each cycle so stale values never look valid
  always @(posedge ref_clk) begin
    if (!busy) begin
      cpu_addr <= ~cpu_addr;
      cpu_data <= ~cpu_data;
    end
  end

  // one instruction, first byte address shown at its start
  task automatic exec(input logic [15:0] a, input int gap);
    busy = 1'b1;
    cpu_addr <= a;
    cpu_insn_start <= 1'b1;
    @(posedge ref_clk);
    cpu_insn_start <= 1'b0;
    repeat (gap) @(posedge ref_clk);
    cpu_insn_done <= 1'b1;
    @(posedge ref_clk);
    cpu_insn_done <= 1'b0;
    busy = 1'b0;
  endtask

  // one data access, byte data on the upper lines
  task automatic access(input logic [15:0] a, input logic [15:0] v, input logic w, input logic b);
    busy = 1'b1;
    cpu_addr <= a;
    cpu_data <= b ? {v[7:0], ~v[7:0]} : v;
    cpu_write <= w;
    cpu_byte <= b;
    cpu_access <= 1'b1;
    @(posedge ref_clk);
    cpu_access <= 1'b0;
    busy = 1'b0;
  endtask

  // return from exception completes
  task automatic return_from_exception();
    cpu_rte_done <= 1'b1;
    @(posedge ref_clk);
    cpu_rte_done <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: tb/abc_break_unit_tb.sv
/*
  Bench of the break unit: a row loop over match modes, then hand tests.
  Assumes the core model and the bound checker are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "abc_defs.vh"

module abc_break_unit_tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] ca;
    logic [15:0] cd;
    logic [1:0] kind;
    logic [15:0] ba;
    logic [15:0] bd;
    logic bt;
    logic hit;
  } abc_row_t;
  localparam logic [19:0] A_CTRL = {`ABC_IDX_CTRL, 2'b00};
  localparam logic [19:0] A_STAT = {`ABC_IDX_STAT, 2'b00};
  localparam logic [19:0] A_ADDR = {`ABC_IDX_ADDR, 2'b00};
  localparam logic [19:0] A_DATA = {`ABC_IDX_DATA, 2'b00};
  localparam logic [19:0] A_ISTAT = {`ABC_IDX_IRQ_STAT, 2'b00};
  localparam logic [19:0] A_IMASK = {`ABC_IDX_IRQ_MASK, 2'b00};
  logic ref_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic break_irq, return_interrupt_unmask, irq;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] cpu_addr, cpu_data;
  logic cpu_insn_start, cpu_insn_done, cpu_access, cpu_write, cpu_byte, cpu_rte_done;
  int fail_count, compares;
  // kind 0 execute, 1 read, 2 write
  abc_row_t rows [13] = '{
    '{8'h00,16'h1234,16'h0,2'd0,16'h1234,16'h0,1'b0,1'b1}, '{8'h00,16'h1234,16'h0,2'd0,16'h1235,16'h0,1'b0,1'b0},
    '{8'h04,16'h1234,16'h0,2'd0,16'h1235,16'h0,1'b0,1'b1}, '{8'h08,16'h1230,16'h0,2'd0,16'h123f,16'h0,1'b0,1'b1},
    '{8'h0c,16'h1200,16'h0,2'd0,16'h12ff,16'h0,1'b0,1'b1}, '{8'h20,16'h4000,16'hffff,2'd1,16'h4000,16'h1234,1'b0,1'b1},
    '{8'h21,16'h4000,16'h0055,2'd1,16'h4000,16'h1155,1'b0,1'b1}, '{8'h22,16'h4000,16'h5500,2'd1,16'h4000,16'h5511,1'b0,1'b1},
    '{8'h23,16'h4000,16'h1234,2'd1,16'h4000,16'h1235,1'b0,1'b0}, '{8'h43,16'h4000,16'h1234,2'd1,16'h4000,16'h1234,1'b0,1'b0},
    '{8'h63,16'h4000,16'h1234,2'd2,16'h4000,16'h1234,1'b0,1'b1}, '{8'h23,16'h4001,16'hab00,2'd1,16'h4001,16'h00ab,1'b1,1'b1},
    '{8'h00,16'h1234,16'h0,2'd1,16'h1234,16'h0,1'b0,1'b0}};

  abc_break_unit i_abc_break_unit (
    .ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cpu_addr, .cpu_data, .cpu_insn_start, .cpu_insn_done,
    .cpu_access, .cpu_write, .cpu_byte, .cpu_rte_done, .break_irq, .return_interrupt_unmask, .irq
  );
  abc_core_model i_abc_core_model (
    .ref_clk, .cpu_addr, .cpu_data, .cpu_insn_start, .cpu_insn_done, .cpu_access, .cpu_write,
    .cpu_byte, .cpu_rte_done
  );

  // counts and verdict
  task automatic report_and_stop();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write, address and data released as each is taken
  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 20);
    resp = s_axi_bresp; // bready stays up, a back-to-back write never drives it twice
    if (!s_axi_bvalid) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // one read, result in d and resp
  task automatic rd(input logic [19:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 20);
    d = s_axi_rdata; // rready stays up, a back-to-back read never drives it twice
    resp = s_axi_rresp;
    if (!s_axi_rvalid) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // main sequence
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 72'h0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(A_CTRL);
    chk(d, 32'h0);
    rd(A_STAT);
    chk(d, 32'h0);
    chk(return_interrupt_unmask, 1'b0);
    foreach (rows[i]) begin
      wr(A_CTRL, {24'h0, rows[i].ctrl});
      wr(A_ADDR, {16'h0, rows[i].ca});
      wr(A_DATA, {16'h0, rows[i].cd});
      wr(A_STAT, 32'h40);
      if (rows[i].kind == 2'd0) i_abc_core_model.exec(rows[i].ba, 1);
      else i_abc_core_model.access(rows[i].ba, rows[i].bd, rows[i].kind[1], rows[i].bt);
      @(negedge ref_clk);
      chk(break_irq, rows[i].hit);
      @(posedge ref_clk);
      rd(A_STAT);
      chk(d, {24'h0, rows[i].hit, 7'h40});
      wr(A_STAT, 32'h40);
      wr(A_ISTAT, 32'h1);
    end
    // execution break waits for the instruction to finish
    wr(A_CTRL, 32'h0);
    wr(A_ADDR, 32'h2000);
    fork
      i_abc_core_model.exec(16'h2000, 3);
      begin
        repeat (5) @(negedge ref_clk); // armed, and still low in the completion cycle
        chk(break_irq, 1'b0);
      end
    join
    @(negedge ref_clk);
    chk(break_irq, 1'b1);
    @(posedge ref_clk);
    // flag clears only by writing 0 after reading 1
    wr(A_STAT, 32'h40);
    rd(A_STAT);
    chk(d, 32'hc0);
    wr(A_STAT, 32'h40);
    rd(A_STAT);
    chk(d, 32'h40);
    wr(A_STAT, 32'hc0);
    rd(A_STAT);
    chk(d, 32'h40);
    // enable gates the request
    wr(A_STAT, 32'h0);
    i_abc_core_model.exec(16'h2000, 0);
    @(negedge ref_clk);
    chk(break_irq, 1'b0);
    @(posedge ref_clk);
    wr(A_STAT, 32'h40);
    chk(break_irq, 1'b1);
    // return masking, then unmasked
    i_abc_core_model.return_from_exception();
    @(negedge ref_clk);
    chk(break_irq, 1'b0);
    @(negedge ref_clk);
    chk(break_irq, 1'b1);
    @(posedge ref_clk);
    wr(A_CTRL, 32'h80);
    chk(return_interrupt_unmask, 1'b1);
    i_abc_core_model.return_from_exception();
    @(negedge ref_clk);
    chk(break_irq, 1'b1);
    @(posedge ref_clk);
    // sticky status, mask, clear by one
    rd(A_ISTAT);
    chk(d, 32'h1);
    chk(irq, 1'b0);
    wr(A_IMASK, 32'h1);
    chk(irq, 1'b1);
    wr(A_ISTAT, 32'h1);
    chk(irq, 1'b0);
    // unmapped place
    rd(20'h00010);
    chk(d, 32'h0);
    chk(resp, `ABC_RESP_SLVERR);
    wr(20'h00010, 32'hffffffff);
    chk(resp, `ABC_RESP_SLVERR);
    report_and_stop();
  end
endmodule

`default_nettype wire
